// ---- shared/lum_regs.svh ----
// register offsets, field positions and reset values of the line unit status block
`ifndef LUM_REGS_SVH
`define LUM_REGS_SVH
`define LUM_ADDR_W        13
`define LUM_OFF_STD_CTRL  13'h1000
`define LUM_OFF_BUILDOUT  13'h1001
`define LUM_OFF_MAINT     13'h1002
`define LUM_OFF_LIVE      13'h1003
`define LUM_OFF_MASK      13'h1004
`define LUM_OFF_LATCH     13'h1005
`define LUM_OFF_LEVEL     13'h1006
`define LUM_OFF_RXMON     13'h1007
`define LUM_RST_BYTE      8'h00
`define LUM_BIT_STD_SEL   1
`define LUM_BIT_ALARM     7
`define LUM_BIT_AUTO_AIS  6
`define LUM_BIT_NEAR_LB   5
`define LUM_BIT_ANA_LB    4
`define LUM_BIT_RET_LB    3
`define LUM_BIT_TX_PD     2
`define LUM_BIT_RX_PD     1
`define LUM_BIT_TX_EN     0
`define LUM_BIT_OVER_EQ   5
`define LUM_BIT_UNDER_EQ  4
`define LUM_BIT_SHORT     2
`define LUM_BIT_OPEN      1
`define LUM_BIT_LOS       0
`define LUM_BIT_CLK_RX    7
`define LUM_CSU_FIRST     3'h5
`endif

// ---- shared/lum_pkg.sv ----
// types shared by the line unit status block
package lum_pkg;
  // live line conditions coming from the analogue front end
  typedef struct packed {
    logic jitter_limit;
    logic open_out;
    logic short_out;
    logic sig_loss;
  } lum_cond_s;

  // host register port access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } lum_host_s;

  // transmit selector state
  typedef enum logic [1:0] {
    LUM_TX_FRAMER,
    LUM_TX_ALARM,
    LUM_TX_RETURN
  } lum_tx_src_e;
endpackage : lum_pkg

// ---- hdl/lum_line_unit.sv ----
// line unit maintenance control, live status, event latches and level reporting
`timescale 1ns/10ps
`include "lum_regs.svh"

module lum_line_unit
  import lum_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire lum_host_s   host,
  output logic [7:0]       rdata,
  input  wire lum_cond_s   cond,
  input  wire logic        over_eq,
  input  wire logic        under_eq,
  input  wire logic [3:0]  level_raw,
  input  wire logic [3:0]  equalizer_gain_cap,
  input  wire logic        short_haul,
  input  wire logic        output_drive_pin,
  input  wire logic        framer_tx_data,
  input  wire logic        rx_line_data,
  output logic             tx_line_data,
  output logic             tx_line_pos_oe,
  output logic             tx_line_neg_oe,
  output logic             rx_to_framer,
  output logic             transmitter_powerdown,
  output logic             receiver_powerdown,
  output logic             near_side_loopback_en,
  output logic             analog_path_loopback_en,
  output logic             line_return_loopback_en,
  output logic             line_clock_receive_en,
  output logic             line_standard_select,
  output logic             irq
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0] std_ctrl_q;
  logic [7:0] buildout_q;
  logic [7:0] maint_q;
  logic [7:0] mask_q;
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] rxmon_q;
  logic [7:0] live_q;
  logic [3:0] level_q;
  logic [3:0] cond_prev_q;
  logic [3:0] cond_now;
  logic [7:0] events;
  logic       csu_mode;
  lum_tx_src_e tx_src;

  function automatic logic hit(input logic [12:0] off);
    hit = host.wr && (host.addr == off);
  endfunction : hit

  always_ff @(posedge mclk) begin
    if (rst) begin
      std_ctrl_q <= `LUM_RST_BYTE;
      buildout_q <= `LUM_RST_BYTE;
      maint_q    <= `LUM_RST_BYTE;
      mask_q     <= `LUM_RST_BYTE;
      rxmon_q    <= `LUM_RST_BYTE;
    end else begin
      if (hit(`LUM_OFF_STD_CTRL)) std_ctrl_q <= host.wdata & 8'h1F;
      if (hit(`LUM_OFF_BUILDOUT)) buildout_q <= host.wdata & 8'h77;
      if (hit(`LUM_OFF_MAINT))    maint_q    <= host.wdata;
      if (hit(`LUM_OFF_MASK))     mask_q     <= host.wdata;
      if (hit(`LUM_OFF_RXMON))    rxmon_q    <= host.wdata;
    end
  end

  // ****************************************************************
  // live status and level code
  // ****************************************************************
  assign cond_now = {cond.jitter_limit, cond.open_out, cond.short_out, cond.sig_loss};

  always_ff @(posedge mclk) begin
    if (rst) begin
      live_q      <= `LUM_RST_BYTE;
      level_q     <= 4'h0;
      cond_prev_q <= 4'h0;
    end else begin
      live_q                    <= 8'h00;
      live_q[`LUM_BIT_OVER_EQ]  <= over_eq;
      live_q[`LUM_BIT_UNDER_EQ] <= under_eq;
      live_q[`LUM_BIT_SHORT]    <= cond.short_out;
      live_q[`LUM_BIT_OPEN]     <= cond.open_out;
      live_q[`LUM_BIT_LOS]      <= cond.sig_loss;
      // short-haul caps the reported code at the gain cap
      if (short_haul && (level_raw > equalizer_gain_cap))
        level_q <= equalizer_gain_cap;
      else
        level_q <= level_raw;
      cond_prev_q <= cond_now;
    end
  end

  // ****************************************************************
  // event latches
  // ****************************************************************
  assign csu_mode = line_standard_select &&
                    (buildout_q[2:0] >= `LUM_CSU_FIRST);

  always_comb begin
    events      = {cond_prev_q & ~cond_now, ~cond_prev_q & cond_now};
    events[1]   = events[1] & ~csu_mode;
    events[2]   = events[2] & ~csu_mode;
    latch_d     = latch_q;
    if (hit(`LUM_OFF_LATCH))
      latch_d   = latch_q & ~host.wdata;
    latch_d     = latch_d | events;
  end

  always_ff @(posedge mclk) begin
    if (rst) latch_q <= `LUM_RST_BYTE;
    else     latch_q <= latch_d;
  end

  assign irq = |(latch_q & mask_q);

  // ****************************************************************
  // maintenance control outputs
  // ****************************************************************
  assign near_side_loopback_en   = maint_q[`LUM_BIT_NEAR_LB];
  assign analog_path_loopback_en = maint_q[`LUM_BIT_ANA_LB];
  assign line_return_loopback_en = maint_q[`LUM_BIT_RET_LB];
  assign transmitter_powerdown   = maint_q[`LUM_BIT_TX_PD];
  assign receiver_powerdown      = maint_q[`LUM_BIT_RX_PD];
  assign line_clock_receive_en   = rxmon_q[`LUM_BIT_CLK_RX];
  assign line_standard_select    = std_ctrl_q[`LUM_BIT_STD_SEL];

  // output enables follow the drive pin gated by transmitter power-down; power-down forces high impedance
  assign tx_line_pos_oe = output_drive_pin && !maint_q[`LUM_BIT_TX_PD];
  assign tx_line_neg_oe = tx_line_pos_oe;

  always_comb begin
    if (maint_q[`LUM_BIT_ALARM] ||
        (maint_q[`LUM_BIT_AUTO_AIS] && cond.sig_loss))
      tx_src = LUM_TX_ALARM;
    else if (maint_q[`LUM_BIT_RET_LB])
      tx_src = LUM_TX_RETURN;
    else
      tx_src = LUM_TX_FRAMER;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_line_data <= 1'b0;
      rx_to_framer <= 1'b0;
    end else begin
      rx_to_framer <= receiver_powerdown ? 1'b0 : rx_line_data;
      case (tx_src)
        LUM_TX_ALARM:  tx_line_data <= 1'b1;
        LUM_TX_RETURN: tx_line_data <= rx_line_data;
        LUM_TX_FRAMER: tx_line_data <= framer_tx_data;
        default:       tx_line_data <= 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) rdata <= `LUM_RST_BYTE;
    else if (host.rd) begin
      case (host.addr)
        `LUM_OFF_STD_CTRL: rdata <= std_ctrl_q;
        `LUM_OFF_BUILDOUT: rdata <= buildout_q;
        `LUM_OFF_MAINT:    rdata <= maint_q;
        `LUM_OFF_LIVE:     rdata <= live_q;
        `LUM_OFF_MASK:     rdata <= mask_q;
        `LUM_OFF_LATCH:    rdata <= latch_q;
        `LUM_OFF_LEVEL:    rdata <= {level_q, 4'h0};
        `LUM_OFF_RXMON:    rdata <= rxmon_q;
        default:           rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_alarm_out;
    @(posedge mclk) disable iff (rst)
      (maint_q[`LUM_BIT_AUTO_AIS] && cond.sig_loss) |=> tx_line_data;
  endproperty
  a_alarm_out: assert property (p_alarm_out) else $error("alarm not sent");

  property p_force_alarm;
    @(posedge mclk) disable iff (rst)
      maint_q[`LUM_BIT_ALARM] |=> tx_line_data;
  endproperty
  a_force_alarm: assert property (p_force_alarm) else $error("forced alarm missing");

  property p_return;
    @(posedge mclk) disable iff (rst)
      (tx_src == LUM_TX_RETURN) |=> (tx_line_data == $past(rx_line_data));
  endproperty
  a_return: assert property (p_return) else $error("return loop wrong");

  property p_pd_hiz;
    @(posedge mclk) disable iff (rst)
      maint_q[`LUM_BIT_TX_PD] |-> !tx_line_pos_oe && !tx_line_neg_oe;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("driving while powered down");

  property p_los_live;
    @(posedge mclk) disable iff (rst)
      ##1 live_q[`LUM_BIT_LOS] == $past(cond.sig_loss);
  endproperty
  a_los_live: assert property (p_los_live) else $error("loss status lag");

  property p_rise_set;
    @(posedge mclk) disable iff (rst)
      (cond.sig_loss && !cond_prev_q[0]) |=> latch_q[0];
  endproperty
  a_rise_set: assert property (p_rise_set) else $error("loss start missed");

  property p_fall_set;
    @(posedge mclk) disable iff (rst)
      (!cond.sig_loss && cond_prev_q[0]) |=> latch_q[4];
  endproperty
  a_fall_set: assert property (p_fall_set) else $error("loss end missed");

  property p_hold;
    @(posedge mclk) disable iff (rst)
      (latch_q[3] && !(host.wr && (host.addr == `LUM_OFF_LATCH))) |=> latch_q[3];
  endproperty
  a_hold: assert property (p_hold) else $error("latch dropped");

  property p_irq;
    @(posedge mclk) disable iff (rst)
      (|(events & mask_q) && !(host.wr && (host.addr == `LUM_OFF_MASK))) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_near_lb;
    @(posedge mclk) disable iff (rst)
      (host.wr && (host.addr == `LUM_OFF_MAINT)) |=>
        (near_side_loopback_en == $past(host.wdata[`LUM_BIT_NEAR_LB]));
  endproperty
  a_near_lb: assert property (p_near_lb) else $error("near loopback bit lost");

  property p_ana_lb;
    @(posedge mclk) disable iff (rst)
      (host.wr && (host.addr == `LUM_OFF_MAINT)) |=>
        (analog_path_loopback_en == $past(host.wdata[`LUM_BIT_ANA_LB]));
  endproperty
  a_ana_lb: assert property (p_ana_lb) else $error("analog loopback bit lost");

  property p_rx_pd;
    @(posedge mclk) disable iff (rst)
      receiver_powerdown |=> !rx_to_framer;
  endproperty
  a_rx_pd: assert property (p_rx_pd) else $error("receiver active while powered down");

  property p_oe_pin;
    @(posedge mclk) disable iff (rst)
      !output_drive_pin |-> !tx_line_pos_oe && !tx_line_neg_oe;
  endproperty
  a_oe_pin: assert property (p_oe_pin) else $error("outputs driven without pin");

  property p_eq_live;
    @(posedge mclk) disable iff (rst)
      ##1 {live_q[`LUM_BIT_OVER_EQ], live_q[`LUM_BIT_UNDER_EQ]} == $past({over_eq, under_eq});
  endproperty
  a_eq_live: assert property (p_eq_live) else $error("equalizer status lag");

  property p_short_live;
    @(posedge mclk) disable iff (rst)
      ##1 live_q[`LUM_BIT_SHORT] == $past(cond.short_out);
  endproperty
  a_short_live: assert property (p_short_live) else $error("short status lag");

  property p_open_live;
    @(posedge mclk) disable iff (rst)
      ##1 live_q[`LUM_BIT_OPEN] == $past(cond.open_out);
  endproperty
  a_open_live: assert property (p_open_live) else $error("open status lag");

  property p_mask_wr;
    @(posedge mclk) disable iff (rst)
      (host.wr && (host.addr == `LUM_OFF_MASK)) |=> (mask_q == $past(host.wdata));
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_csu_quiet;
    @(posedge mclk) disable iff (rst)
      (csu_mode && cond.open_out && !cond_prev_q[2] && !latch_q[2]) |=> !latch_q[2];
  endproperty
  a_csu_quiet: assert property (p_csu_quiet) else $error("open start latched in csu");

  property p_level;
    @(posedge mclk) disable iff (rst)
      !short_haul |=> (level_q == $past(level_raw));
  endproperty
  a_level: assert property (p_level) else $error("level code lag");

  property p_level_cap;
    @(posedge mclk) disable iff (rst)
      short_haul |=> (level_q <= $past(equalizer_gain_cap));
  endproperty
  a_level_cap: assert property (p_level_cap) else $error("level code above cap");

  property p_clk_rx;
    @(posedge mclk) disable iff (rst)
      (host.wr && (host.addr == `LUM_OFF_RXMON)) |=>
        (line_clock_receive_en == $past(host.wdata[`LUM_BIT_CLK_RX]));
  endproperty
  a_clk_rx: assert property (p_clk_rx) else $error("clock receive bit lost");

  property p_std_sel;
    @(posedge mclk) disable iff (rst)
      (host.wr && (host.addr == `LUM_OFF_STD_CTRL)) |=>
        (line_standard_select == $past(host.wdata[`LUM_BIT_STD_SEL]));
  endproperty
  a_std_sel: assert property (p_std_sel) else $error("standard select lost");

  property p_w1c;
    @(posedge mclk) disable iff (rst)
      (host.wr && (host.addr == `LUM_OFF_LATCH) && host.wdata[3] && !events[3]) |=>
        !latch_q[3];
  endproperty
  a_w1c: assert property (p_w1c) else $error("latch not cleared");

endmodule : lum_line_unit

// ---- test/lum_line_model.sv ----
// far-side model: line conditions, receive line data and framer data
`timescale 1ns/10ps
module lum_line_model
  import lum_pkg::*;
(
  input  wire logic      mclk,
  input  wire lum_cond_s cond_req,
  input  wire logic      rx_req,
  output lum_cond_s      cond,
  output logic           rx_line_data,
  output logic           framer_tx_data
);
  // ************************************
  // line and framer drivers
  // ************************************
  // framer sends the inverse of the line so the two sources never agree
  always @(posedge mclk) begin
    cond <= cond_req;
    rx_line_data <= rx_req;
    framer_tx_data <= ~rx_req;
  end
endmodule : lum_line_model

// ---- test/tb.sv ----
// self-checking bench for the line unit status block
`timescale 1ns/10ps
`include "lum_regs.svh"
module tb
  import lum_pkg::*;
;
  // ************************************
  // signals, model and design
  // ************************************
  logic mclk = 0, rst = 1, short_haul = 0, over_eq = 0, under_eq = 0;
  logic output_drive_pin = 0, rxr = 0, rd_p = 0;
  logic [3:0] level_raw = 4'h0, equalizer_gain_cap = 4'h0;
  logic [7:0] rdata, d, exp_q[$];
  logic [9:0] tv[5] = '{10'h020, 10'h001, 10'h221, 10'h120, 10'h123};
  lum_host_s host = '0;
  lum_cond_s creq = 4'h0, cond;
  logic rx_line_data, framer_tx_data, tx_line_data, tx_line_pos_oe, tx_line_neg_oe;
  logic rx_to_framer, transmitter_powerdown, receiver_powerdown, near_side_loopback_en;
  logic analog_path_loopback_en, line_return_loopback_en, line_clock_receive_en;
  logic line_standard_select, irq;
  int fail_count = 0, samples_checked = 0, seed = 62, i;

  lum_line_model u_line (.mclk, .cond_req(creq), .rx_req(rxr), .cond, .rx_line_data,
    .framer_tx_data);
  lum_line_unit DUT (.mclk, .rst, .host, .rdata, .cond, .over_eq, .under_eq, .level_raw,
    .equalizer_gain_cap, .short_haul, .output_drive_pin, .framer_tx_data, .rx_line_data,
    .tx_line_data, .tx_line_pos_oe, .tx_line_neg_oe, .rx_to_framer, .transmitter_powerdown,
    .receiver_powerdown, .near_side_loopback_en, .analog_path_loopback_en,
    .line_return_loopback_en, .line_clock_receive_en, .line_standard_select, .irq);

  initial forever #20 mclk = ~mclk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : w

  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    @(posedge mclk);
    host <= '{1'h0, 1'h1, a, v};
    @(posedge mclk);
    host.wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    @(posedge mclk);
    host <= '{1'h1, 1'h0, a, 8'h00};
    exp_q.push_back(e);
    @(posedge mclk);
    host.rd <= 1'h0;
  endtask : rd

  // read data lands the cycle after the read strobe is taken
  always @(posedge mclk) rd_p <= host.rd;
  always @(negedge mclk) if (rd_p) chk(rdata, exp_q.pop_front());

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end

  // ************************************
  // scenarios
  // ************************************
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    for (i = 2; i < 8; i++) rd(13'(13'h1000 + i), 8'h00);
    rd(13'h1010, 8'h00);
    d = 8'($random(seed));
    wr(`LUM_OFF_MASK, d);
    rd(`LUM_OFF_MASK, d);
    wr(`LUM_OFF_LIVE, 8'hFF);
    rd(`LUM_OFF_LIVE, 8'h00);
    $display("register test done");
    for (i = 0; i < 4; i++) begin
      wr(`LUM_OFF_MASK, 8'hFF ^ (8'h01 << i));
      @(posedge mclk) creq[i] <= 1'h1;
      w(3);
      chk(irq, 1'h0);
      rd(`LUM_OFF_LATCH, 8'h01 << i);
      wr(`LUM_OFF_MASK, 8'hFF);
      w(1);
      chk(irq, 1'h1);
      wr(`LUM_OFF_LATCH, 8'h00);
      rd(`LUM_OFF_LATCH, 8'h01 << i);
      wr(`LUM_OFF_LATCH, 8'h01 << i);
      rd(`LUM_OFF_LATCH, 8'h00);
      #1 chk(irq, 1'h0);
      @(posedge mclk) creq[i] <= 1'h0;
      w(3);
      rd(`LUM_OFF_LATCH, 8'h10 << i);
      wr(`LUM_OFF_LATCH, 8'hFF);
    end
    $display("event test done");
    @(posedge mclk) creq <= 4'h7;
    over_eq <= 1'h1;
    w(3);
    rd(`LUM_OFF_LIVE, 8'h27);
    @(posedge mclk) creq <= 4'h0;
    over_eq <= 1'h0;
    under_eq <= 1'h1;
    w(3);
    rd(`LUM_OFF_LIVE, 8'h10);
    wr(`LUM_OFF_LATCH, 8'hFF);
    wr(`LUM_OFF_STD_CTRL, 8'h02);
    wr(`LUM_OFF_BUILDOUT, 8'h05);
    @(posedge mclk) creq <= 4'h4;
    w(3);
    chk(line_standard_select, 1'h1);
    rd(`LUM_OFF_LATCH, 8'h00);
    @(posedge mclk) creq <= 4'h0;
    w(3);
    rd(`LUM_OFF_LATCH, 8'h40);
    $display("status test done");
    for (i = 0; i < 4; i++) begin
      @(posedge mclk) {level_raw, equalizer_gain_cap} <= 8'($random(seed));
      short_haul <= 1'h0;
      w(2);
      rd(`LUM_OFF_LEVEL, {level_raw, 4'h0});
      @(posedge mclk) short_haul <= 1'h1;
      w(2);
      d[3:0] = (level_raw > equalizer_gain_cap) ? equalizer_gain_cap : level_raw;
      rd(`LUM_OFF_LEVEL, {d[3:0], 4'h0});
    end
    wr(`LUM_OFF_RXMON, 8'h80);
    w(1);
    chk(line_clock_receive_en, 1'h1);
    $display("level test done");
    @(posedge mclk) output_drive_pin <= 1'h1;
    for (i = 0; i < 2; i++) begin
      d = i ? 8'h14 : 8'h2A;
      wr(`LUM_OFF_MAINT, d);
      w(2);
      chk({near_side_loopback_en, analog_path_loopback_en, line_return_loopback_en,
        transmitter_powerdown, receiver_powerdown}, d[5:1]);
      chk({tx_line_pos_oe, tx_line_neg_oe}, d[2] ? 8'h0 : 8'h3);
    end
    wr(`LUM_OFF_MAINT, 8'h01);
    @(posedge mclk) output_drive_pin <= 1'h0;
    w(2);
    chk({tx_line_pos_oe, tx_line_neg_oe}, 8'h0);
    for (i = 0; i < 5; i++) begin
      wr(`LUM_OFF_MAINT, tv[i][9:2]);
      @(posedge mclk) creq <= {3'h0, tv[i][1]};
      w(4);
      chk(tx_line_data, tv[i][0]);
    end
    chk(rx_to_framer, 1'h0);
    wr(`LUM_OFF_MAINT, 8'h08);
    for (i = 0; i < 8; i++) begin
      @(posedge mclk) rxr <= 1'($random(seed));
      w(2);
      chk(tx_line_data, rxr);
      chk(rx_to_framer, rxr);
    end
    wr(`LUM_OFF_MAINT, 8'h0A);
    @(posedge mclk) rxr <= 1'h1;
    w(2);
    chk(rx_to_framer, 1'h0);
    $display("maintenance test done");
    w(3);
    end_of_test();
  end
endmodule : tb
